// ==== src/flash_status_poller.v ====
`timescale 1ns/10ps
`include "flash_poll_map.vh"

// How it works
// - Reported status masks reserved bits 0, 1 and 4.
// - Polling is started only after the full command sequence is written.
// - Poll at the programmed address or inside the erased block.
// - Two consecutive equal bit 6 reads mean done; next read is final.
// - Bit 3 high means erase started; only suspend may follow.
module flash_status_poller #(
    parameter AW            = 19,
    parameter STROBE_CYC    = `STROBE_CYC,
    parameter ERASE_WIN_CYC = `ERASE_WIN_CYC,
    parameter POLL_LIMIT    = `POLL_LIMIT
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          cmd_valid,
    input  wire [2:0]    cmd_kind,
    input  wire [AW-1:0] cmd_addr,
    input  wire [15:0]   cmd_data,
    output reg           cmd_ready,
    output reg           rsp_valid,
    output reg  [1:0]    rsp_code,
    output reg  [15:0]   rsp_data,
    output reg  [7:0]    rsp_status,
    output reg           erase_started,
    output wire [AW-1:0] flash_addr,
    output wire          flash_ce_n,
    output wire          flash_oe_n,
    output wire          flash_we_n,
    output wire [15:0]   flash_dq_o,
    output wire          flash_dq_oe_n,
    input  wire [15:0]   flash_dq_i
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam ST_IDLE  = 3'h0;
    localparam ST_PLAIN = 3'h1;
    localparam ST_FIRST = 3'h2;
    localparam ST_LOOP  = 3'h3;
    localparam ST_ERR   = 3'h4;
    localparam ST_FINAL = 3'h5;
    localparam ST_TIMER = 3'h6;

    localparam [31:0] WIN_LIM  = ERASE_WIN_CYC;
    localparam [15:0] POLL_LIM = POLL_LIMIT;

    reg  [2:0]    st_q;
    reg  [2:0]    kind_q;
    reg  [AW-1:0] addr_q;
    reg           exp7_q;
    reg  [15:0]   prev_q;
    reg  [15:0]   reads_q;
    reg  [31:0]   win_q;
    reg           fail_q;
    reg           go_q;
    reg           wr_q;
    wire          bus_done;
    wire [15:0]   bus_rdata;
    wire          tog_same;
    wire          dp_match;

    // ------------------------------------------------------------------
    // Bus cycle engine
    // ------------------------------------------------------------------
    flash_bus_cycle #(
        .AW         (AW),
        .STROBE_CYC (STROBE_CYC)
    ) u_bus (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .start         (go_q),
        .is_write      (wr_q),
        .addr          (addr_q),
        .wdata         (prev_q),
        .done          (bus_done),
        .rdata         (bus_rdata),
        .flash_addr    (flash_addr),
        .flash_ce_n    (flash_ce_n),
        .flash_oe_n    (flash_oe_n),
        .flash_we_n    (flash_we_n),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_n (flash_dq_oe_n),
        .flash_dq_i    (flash_dq_i)
    );

    // Completion tests on the word just read
    assign tog_same = bus_rdata[`PRIMARY_TOGGLE_BIT] == prev_q[`PRIMARY_TOGGLE_BIT];
    assign dp_match = bus_rdata[`DATA_POLLING_BIT] == exp7_q;

    // ------------------------------------------------------------------
    // Poll sequencer
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q          <= ST_IDLE;
            kind_q        <= `CMD_READ;
            addr_q        <= {AW{1'b0}};
            exp7_q        <= 1'b0;
            prev_q        <= 16'h0000;
            reads_q       <= 16'h0000;
            win_q         <= 32'h00000000;
            fail_q        <= 1'b0;
            go_q          <= 1'b0;
            wr_q          <= 1'b0;
            cmd_ready     <= 1'b1;
            rsp_valid     <= 1'b0;
            rsp_code      <= `RSP_OK;
            rsp_data      <= 16'h0000;
            rsp_status    <= 8'h00;
            erase_started <= 1'b0;
        end else begin
            go_q      <= 1'b0;
            rsp_valid <= 1'b0;
            if (st_q == ST_TIMER && win_q != WIN_LIM) begin
                win_q <= win_q + 32'h00000001;
            end
            case (st_q)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        // Poll commands are given once the sequence is written
                        kind_q    <= cmd_kind;
                        addr_q    <= cmd_addr;
                        prev_q    <= cmd_data;
                        exp7_q    <= cmd_data[`DATA_POLLING_BIT];
                        wr_q      <= cmd_kind == `CMD_WRITE;
                        go_q      <= 1'b1;
                        reads_q   <= 16'h0000;
                        win_q     <= 32'h00000000;
                        fail_q    <= 1'b0;
                        cmd_ready <= 1'b0;
                        if (cmd_kind == `CMD_WRITE || cmd_kind == `CMD_READ) begin
                            st_q <= ST_PLAIN;
                        end else if (cmd_kind == `CMD_WAIT_TIMER) begin
                            st_q          <= ST_TIMER;
                            erase_started <= 1'b0;
                        end else if (cmd_kind == `CMD_POLL_TOGGLE) begin
                            st_q <= ST_FIRST;
                        end else begin
                            st_q <= ST_LOOP;
                        end
                    end
                end
                ST_PLAIN: begin
                    if (bus_done) begin
                        // Other-bank reads come back as array data
                        rsp_data  <= wr_q ? prev_q : bus_rdata;
                        rsp_code  <= `RSP_OK;
                        rsp_valid <= 1'b1;
                        cmd_ready <= 1'b1;
                        st_q      <= ST_IDLE;
                    end
                end
                ST_FIRST: begin
                    if (bus_done) begin
                        prev_q <= bus_rdata;
                        go_q   <= 1'b1;
                        st_q   <= ST_LOOP;
                    end
                end
                ST_LOOP: begin
                    if (bus_done) begin
                        prev_q  <= bus_rdata;
                        reads_q <= reads_q + 16'h0001;
                        go_q    <= 1'b1;
                        if (kind_q == `CMD_POLL_TOGGLE ? tog_same : dp_match) begin
                            st_q <= ST_FINAL;
                        end else if (bus_rdata[`FAILURE_FLAG_BIT]) begin
                            st_q <= ST_ERR;
                        end else if (reads_q == POLL_LIM) begin
                            go_q      <= 1'b0;
                            rsp_code  <= `RSP_TIMEOUT;
                            rsp_data  <= bus_rdata;
                            rsp_valid <= 1'b1;
                            cmd_ready <= 1'b1;
                            st_q      <= ST_IDLE;
                        end
                    end
                end
                ST_ERR: begin
                    // Re-read after the failure flag: still busy means failed
                    if (bus_done) begin
                        prev_q <= bus_rdata;
                        go_q   <= 1'b1;
                        fail_q <= kind_q == `CMD_POLL_TOGGLE ? ~tog_same : ~dp_match;
                        st_q   <= ST_FINAL;
                    end
                end
                ST_FINAL: begin
                    if (bus_done) begin
                        rsp_data   <= bus_rdata;
                        // Reserved bits masked from the status view
                        rsp_status <= prev_q[7:0] & `STATUS_MASK;
                        rsp_code   <= fail_q ? `RSP_FAIL : `RSP_OK;
                        rsp_valid  <= 1'b1;
                        cmd_ready  <= 1'b1;
                        st_q       <= ST_IDLE;
                    end
                end
                ST_TIMER: begin
                    if (bus_done) begin
                        prev_q <= bus_rdata;
                        if (bus_rdata[`ERASE_TIMER_BIT]) begin
                            // Erase running: only suspend may be sent now
                            erase_started <= 1'b1;
                            rsp_code      <= `RSP_OK;
                        end else if (win_q == WIN_LIM) begin
                            rsp_code <= `RSP_TIMEOUT;
                        end
                        if (bus_rdata[`ERASE_TIMER_BIT] || win_q == WIN_LIM) begin
                            rsp_data   <= bus_rdata;
                            rsp_status <= bus_rdata[7:0] & `STATUS_MASK;
                            rsp_valid  <= 1'b1;
                            cmd_ready  <= 1'b1;
                            st_q       <= ST_IDLE;
                        end else begin
                            go_q <= 1'b1;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
endmodule // flash_status_poller

// ==== src/flash_poll_map.vh ====
`ifndef FLASH_POLL_MAP_VH
`define FLASH_POLL_MAP_VH

// ----------------------------------------------------------------------
// User command kinds
// ----------------------------------------------------------------------
`define CMD_WRITE        3'h0
`define CMD_READ         3'h1
`define CMD_POLL_TOGGLE  3'h2
`define CMD_POLL_DATA    3'h3
`define CMD_WAIT_TIMER   3'h4

// ----------------------------------------------------------------------
// Status byte bit positions of program_erase_status
// ----------------------------------------------------------------------
`define DATA_POLLING_BIT    7
`define PRIMARY_TOGGLE_BIT  6
`define FAILURE_FLAG_BIT    5
`define ERASE_TIMER_BIT     3
`define ERASE_TOGGLE_BIT    2
// Keeps bits 7,6,5,3,2; clears reserved bits 4,1,0
`define STATUS_MASK         8'hEC

// ----------------------------------------------------------------------
// Response codes
// ----------------------------------------------------------------------
`define RSP_OK       2'h0
`define RSP_FAIL     2'h1
`define RSP_TIMEOUT  2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     20
// Strobe low time of one bus cycle (least time, rounds up)
`define STROBE_NS         140
`define STROBE_CYC        ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest erase timeout window before the erase starts
`define ERASE_WIN_US      120
`define ERASE_WIN_CYC     ((`ERASE_WIN_US * 1000) / `CLK_PERIOD_NS)
// Reads allowed per poll before giving up
`define POLL_LIMIT        16'hFFFF

`endif

// ==== src/flash_bus_cycle.v ====
`timescale 1ns/10ps
`include "flash_poll_map.vh"

// One asynchronous flash bus cycle: setup, strobe, sample, recovery
module flash_bus_cycle #(
    parameter AW         = 19,
    parameter STROBE_CYC = `STROBE_CYC
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          start,
    input  wire          is_write,
    input  wire [AW-1:0] addr,
    input  wire [15:0]   wdata,
    output reg           done,
    output reg  [15:0]   rdata,
    output reg  [AW-1:0] flash_addr,
    output reg           flash_ce_n,
    output reg           flash_oe_n,
    output reg           flash_we_n,
    output reg  [15:0]   flash_dq_o,
    output reg           flash_dq_oe_n,
    input  wire [15:0]   flash_dq_i
);
    localparam PH_IDLE   = 2'h0;
    localparam PH_SETUP  = 2'h1;
    localparam PH_STROBE = 2'h2;
    localparam PH_REC    = 2'h3;
    // Two extra strobe cycles cover the input synchroniser delay
    localparam [31:0] LAST_FULL = STROBE_CYC + 1;
    localparam [7:0]  LAST      = LAST_FULL[7:0];

    reg [1:0]  ph_q;
    reg [7:0]  cnt_q;
    reg        wr_q;
    reg [15:0] dq_meta_q;
    reg [15:0] dq_sync_q;

    // ------------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dq_meta_q <= 16'h0000;
            dq_sync_q <= 16'h0000;
        end else begin
            dq_meta_q <= flash_dq_i;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Cycle sequencer; recovery raises chip enable so each read is new
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_q          <= PH_IDLE;
            cnt_q         <= 8'h00;
            wr_q          <= 1'b0;
            done          <= 1'b0;
            rdata         <= 16'h0000;
            flash_addr    <= {AW{1'b0}};
            flash_ce_n    <= 1'b1;
            flash_oe_n    <= 1'b1;
            flash_we_n    <= 1'b1;
            flash_dq_o    <= 16'h0000;
            flash_dq_oe_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (ph_q)
                PH_IDLE: begin
                    if (start) begin
                        ph_q          <= PH_SETUP;
                        wr_q          <= is_write;
                        flash_addr    <= addr;
                        flash_dq_o    <= wdata;
                        flash_dq_oe_n <= ~is_write;
                        flash_ce_n    <= 1'b0;
                    end
                end
                PH_SETUP: begin
                    ph_q       <= PH_STROBE;
                    cnt_q      <= 8'h00;
                    flash_we_n <= ~wr_q;
                    flash_oe_n <= wr_q;
                end
                PH_STROBE: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == LAST) begin
                        ph_q       <= PH_REC;
                        rdata      <= dq_sync_q;
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                    end
                end
                PH_REC: begin
                    ph_q          <= PH_IDLE;
                    flash_ce_n    <= 1'b1;
                    flash_dq_oe_n <= 1'b1;
                    done          <= 1'b1;
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end
endmodule // flash_bus_cycle

// ==== test/flash_status_poller_assertions.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the status poller
// ----------------------------------------
module flash_status_poller_chk (
    input wire       clk_sys,
    input wire       rst,
    input wire       cmd_valid,
    input wire [2:0] cmd_kind,
    input wire       cmd_ready,
    input wire       rsp_valid,
    input wire [1:0] rsp_code,
    input wire [7:0] rsp_status,
    input wire       erase_started,
    input wire       flash_ce_n,
    input wire       flash_oe_n,
    input wire       flash_we_n,
    input wire       flash_dq_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Status, strobe and handshake relations
    property p_mask; rsp_status[4] == 1'b0 && rsp_status[1:0] == 2'h0; endproperty
    a_mask: assert property (p_mask) else $error("reserved status bit reported");
    property p_rw; !(!flash_oe_n && !flash_we_n); endproperty
    a_rw: assert property (p_rw) else $error("read and write strobes overlap");
    property p_ce; (!flash_oe_n || !flash_we_n) |-> !flash_ce_n; endproperty
    a_ce: assert property (p_ce) else $error("strobe without chip enable");
    property p_nodrive; !flash_oe_n |-> flash_dq_oe_n; endproperty
    a_nodrive: assert property (p_nodrive) else $error("host drives bus during read");
    property p_rdw; $fell(flash_oe_n) |-> (!flash_oe_n) [*8]; endproperty
    a_rdw: assert property (p_rdw) else $error("read strobe too short");
    property p_newrd; $rose(flash_oe_n) |=> flash_ce_n; endproperty
    a_newrd: assert property (p_newrd) else $error("chip enable kept across reads");
    property p_take; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
    a_take: assert property (p_take) else $error("ready kept after taking");
    property p_wlat; cmd_valid && cmd_ready && cmd_kind == 3'h0 |-> ##14 rsp_valid; endproperty
    a_wlat: assert property (p_wlat) else $error("write response late or early");
    property p_pulse; rsp_valid |-> cmd_ready ##1 !rsp_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("bad response pulse");
    property p_start; $rose(erase_started) |-> ##[0:4] (rsp_valid && rsp_code == 2'h0); endproperty
    a_start: assert property (p_start) else $error("erase start without ok");
endmodule // flash_status_poller_chk

bind flash_status_poller flash_status_poller_chk flash_status_poller_chk_i (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .rsp_status(rsp_status), .erase_started(erase_started), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_oe_n(flash_dq_oe_n));

// ==== test/flash_dev_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Dual-bank flash model, bank 0 is busy
// ----------------------------------------
module flash_dev_model #(
    parameter AW = 19
) (
    input  wire          load,
    input  wire [1:0]    op,
    input  wire [7:0]    busy_reads,
    input  wire          fail,
    input  wire [7:0]    timer_reads,
    input  wire [AW-1:0] flash_addr,
    input  wire          flash_ce_n,
    input  wire          flash_oe_n,
    input  wire          flash_we_n,
    input  wire [15:0]   flash_dq_o,
    input  wire          flash_dq_oe_n,
    output wire [15:0]   flash_dq_i
);
    // op: 0 idle, 1 program, 2 erase, 3 erase suspend
    reg [15:0] word_q = 16'h0000;
    reg [15:0] out_q  = 16'h0000;
    reg        tg_q   = 1'b0;
    reg        tg2_q  = 1'b0;
    reg [7:0]  busy_q = 8'h00;
    reg [7:0]  tmr_q  = 8'h00;
    reg [7:0]  st;

    // New operation restarts toggles and reloads the busy and timer read counts
    always @(posedge load) begin
        tg_q = 1'b0;
        tg2_q = 1'b0;
        busy_q = busy_reads;
        tmr_q = timer_reads;
    end
    // Last word written is the one polling refers to
    always @(posedge flash_we_n) begin
        if (!flash_ce_n && !flash_dq_oe_n) word_q = flash_dq_o;
    end
    // A new read starts on output enable, or chip enable while output enable is low
    always @(negedge flash_oe_n or negedge flash_ce_n) begin
        if (!flash_ce_n && !flash_oe_n) begin
            if (flash_addr[AW-1] || op == 2'h0) begin
                out_q = flash_addr[15:0] ^ 16'h5A5A;
            end else if (busy_q == 8'h00 && !fail && op != 2'h3) begin
                out_q = (op == 2'h1) ? word_q : 16'hFFFF;
            end else begin
                if (op != 2'h3) tg_q = ~tg_q;
                tg2_q = ~tg2_q;
                st[7] = (op == 2'h1) ? ~word_q[7] : (op == 2'h3);
                st[6] = tg_q | (op == 2'h3);
                st[5] = fail && busy_q == 8'h00;
                st[4] = 1'b1; // Reserved, high so masking shows
                st[3] = (tmr_q == 8'h00);
                st[2] = (op == 2'h1) | ((op == 2'h3 || fail) & tg2_q);
                st[1:0] = 2'h3;
                out_q = {8'h00, st};
                if (busy_q != 8'h00) busy_q = busy_q - 8'h01;
                if (tmr_q != 8'h00) tmr_q = tmr_q - 8'h01;
            end
        end
    end
    // Released bus shows the inverse of the last value
    assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? out_q : ~out_q;
endmodule // flash_dev_model

// ==== test/flash_status_poller_tb_top.sv ====
`timescale 1ns/10ps
module flash_status_poller_tb_top;
    typedef struct {
        logic [2:0] kind; logic [18:0] addr; logic [15:0] data; logic [1:0] op;
        logic [7:0] busy; logic fail; logic [1:0] code; logic [15:0] xdata;
        logic [7:0] xstat; logic [1:0] chk;
    } row_t;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg         cmd_valid = 1'b0;
    reg  [2:0]  cmd_kind = 3'h0;
    reg  [18:0] cmd_addr = 19'h00000;
    reg  [15:0] cmd_data = 16'h0000;
    reg         m_load = 1'b0;
    reg  [1:0]  m_op = 2'h0;
    reg  [7:0]  m_busy = 8'h00;
    reg         m_fail = 1'b0;
    reg  [7:0]  m_tmr = 8'h00;
    wire        cmd_ready, rsp_valid, erase_started, ce_n, oe_n, we_n, dq_oe_n;
    wire [1:0]  rsp_code;
    wire [15:0] rsp_data, dq_o, dq_i;
    wire [7:0]  rsp_status;
    wire [18:0] f_addr;
    integer     err_count = 0;
    integer     num_checks = 0;
    integer     i;
    row_t       rows [0:7];

    // Poller with a short erase window and poll limit
    flash_status_poller #(.ERASE_WIN_CYC(50), .POLL_LIMIT(16'h0020)) flash_status_poller_i (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data),
        .rsp_status(rsp_status), .erase_started(erase_started), .flash_addr(f_addr),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_dq_o(dq_o),
        .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i));
    flash_dev_model flash_dev_model_i (
        .load(m_load), .op(m_op), .busy_reads(m_busy), .fail(m_fail), .timer_reads(m_tmr),
        .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i));

    // Clock
    always #10 clk_sys = ~clk_sys;

    // Closing report
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Compare seen against expected
    task check(input [15:0] seen, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Load a new device state
    task set_dev(input [1:0] op, input [7:0] busy, input f, input [7:0] tmr);
        begin
            @(posedge clk_sys);
            m_op <= op;
            m_busy <= busy;
            m_fail <= f;
            m_tmr <= tmr;
            @(posedge clk_sys);
            m_load <= 1'b1;
            @(posedge clk_sys);
            m_load <= 1'b0;
        end
    endtask
    // Present one request; it is taken at the next edge
    task issue(input [2:0] k, input [18:0] a, input [15:0] d);
        begin
            @(posedge clk_sys);
            cmd_valid <= 1'b1;
            cmd_kind <= k;
            cmd_addr <= a;
            cmd_data <= d;
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
        end
    endtask
    // Request and bounded wait for the response
    task run_cmd(input [2:0] k, input [18:0] a, input [15:0] d);
        integer n;
        begin
            issue(k, a, d);
            n = 0;
            while (rsp_valid !== 1'b1 && n < 4000) begin
                @(posedge clk_sys);
                #1;
                n = n + 1;
            end
            if (n >= 4000) begin
                err_count = err_count + 1;
                give_verdict;
            end
        end
    endtask

    // Main sequence
    initial begin
        rows[0] = '{3'h0, 19'h00010, 16'h1284, 2'h0, 8'h00, 1'b0, 2'h0, 16'h1284, 8'h00, 2'h1};
        rows[1] = '{3'h1, 19'h40005, 16'h0000, 2'h1, 8'h05, 1'b0, 2'h0, 16'h5A5F, 8'h00, 2'h1};
        rows[2] = '{3'h1, 19'h00010, 16'h0000, 2'h1, 8'h05, 1'b0, 2'h0, 16'h005F, 8'h00, 2'h1};
        rows[3] = '{3'h2, 19'h00010, 16'h0000, 2'h1, 8'h03, 1'b0, 2'h0, 16'h1284, 8'h84, 2'h3};
        rows[4] = '{3'h3, 19'h00020, 16'h0080, 2'h2, 8'h03, 1'b0, 2'h0, 16'hFFFF, 8'hEC, 2'h3};
        rows[5] = '{3'h2, 19'h00010, 16'h0000, 2'h1, 8'h00, 1'b1, 2'h1, 16'h003F, 8'h6C, 2'h3};
        rows[6] = '{3'h3, 19'h00020, 16'h0080, 2'h2, 8'h01, 1'b1, 2'h1, 16'h0000, 8'h00, 2'h0};
        rows[7] = '{3'h2, 19'h00020, 16'h0000, 2'h3, 8'h00, 1'b0, 2'h0, 16'h00DF, 8'hC8, 2'h3};
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check({10'h000, cmd_ready, ce_n, oe_n, we_n, dq_oe_n, rsp_valid}, 16'h003E);
        for (i = 0; i < 8; i = i + 1) begin
            set_dev(rows[i].op, rows[i].busy, rows[i].fail, 8'h00);
            run_cmd(rows[i].kind, rows[i].addr, rows[i].data);
            check({14'h0000, rsp_code}, {14'h0000, rows[i].code});
            if (rows[i].chk[0]) check(rsp_data, rows[i].xdata);
            if (rows[i].chk[1]) check({8'h00, rsp_status}, {8'h00, rows[i].xstat});
        end
        // Erase timer reaches its end, then a window that runs out first
        set_dev(2'h2, 8'h0A, 1'b0, 8'h03);
        run_cmd(3'h4, 19'h00020, 16'h0000);
        check({13'h0000, erase_started, rsp_code}, 16'h0004);
        check({8'h00, rsp_status}, 16'h0008);
        set_dev(2'h2, 8'hC8, 1'b0, 8'hC8);
        run_cmd(3'h4, 19'h00020, 16'h0000);
        check({13'h0000, erase_started, rsp_code}, 16'h0002);
        // Poll that never settles runs out of reads, then a reset cuts the next poll
        set_dev(2'h1, 8'hC8, 1'b0, 8'h00);
        run_cmd(3'h2, 19'h00010, 16'h0000);
        check({14'h0000, rsp_code}, 16'h0002);
        check(rsp_data, 16'h001F);
        issue(3'h2, 19'h00010, 16'h0000);
        repeat (30) @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check({10'h000, cmd_ready, ce_n, oe_n, we_n, dq_oe_n, rsp_valid}, 16'h003E);
        run_cmd(3'h1, 19'h40007, 16'h0000);
        check(rsp_data, 16'h5A5D);
        give_verdict;
    end
endmodule // flash_status_poller_tb_top
